// ### src/pin_ctrl_pkg.sv
package pin_ctrl_pkg;

  // clock and reset timing
  localparam int unsigned CLK_PERIOD_PS    = 40000;
  localparam int unsigned RST_MIN_NS       = 300;
  localparam int unsigned RST_MIN_CYCLES   =
    ((RST_MIN_NS * 1000) + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // loop mode encoding
  localparam logic MODE_NORMAL  = 1'b0;
  localparam logic MODE_FREERUN = 1'b1;

  // mode select register address and field
  localparam logic [7:0] MODESEL_ADDR    = 8'h1f;
  localparam int unsigned MODESEL_BIT    = 0;

  // output frequency select codes, differential output
  localparam logic [3:0] DIFF_SEL_W      = 4'h4;
  localparam logic [3:0] DIFF_SEL_DEF    = 4'h7;
  localparam logic [3:0] DIFF_SONET_MAX  = 4'h7;
  localparam logic [3:0] DIFF_ETH_MAX    = 4'h5;

  // apll output select codes
  localparam logic [3:0] APLL_SEL_DEF    = 4'h4;
  localparam logic [3:0] APLL_SONET_MAX  = 4'h4;
  localparam logic [3:0] APLL_ETH_MAX    = 4'h3;

  // synthesizer clock in units of 8 khz, zero means 2 khz
  localparam logic [13:0] SYNTH_MULT_DEF = 14'h0100;
  localparam logic [13:0] SYNTH_MULT_MAX = 14'h30d4;

  // synthesizer frame pulse select, default 8 khz
  localparam logic [3:0] FP_SEL_DEF      = 4'h0;

endpackage

// ### src/sync2.sv
`timescale 1ns/1ps
module sync2 #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } state_t;

  state_t st_q;
  state_t st_d;

  always_comb begin
    st_d    = st_q;
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
  end

  // no reset here, so a strap level is already carried through while reset is low
  always_ff @(posedge clk) begin
    st_q <= st_d;
  end

  assign q = st_q.s2;
endmodule // sync2

// ### src/pin_ctrl.sv
`timescale 1ns/1ps
module pin_ctrl (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        mode_pin,
  input  wire logic        diff_en_pin,
  input  wire logic        i2c_en_pin,
  input  wire logic        ethernet_mode,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        mode_from_reg,
  input  wire logic [3:0]  diff_sel_req,
  input  wire logic        diff_sel_wr,
  input  wire logic [3:0]  apll_sel_req,
  input  wire logic        apll_sel_wr,
  input  wire logic [13:0] synth_mult_req,
  input  wire logic        synth_mult_wr,
  input  wire logic [3:0]  fp_sel_req,
  input  wire logic        fp_sel_wr,
  input  wire logic        tx_freq_locked,
  input  wire logic        tx_phase_locked,
  input  wire logic        tx_holdover,
  input  wire logic        status_event,
  input  wire logic        int_ack,
  input  wire logic        sck_scl_in,
  input  wire logic        si_sda_in,
  input  wire logic        select_or_addr0_pin,
  input  wire logic        i2c_scl_drive_low,
  input  wire logic        i2c_sda_drive_low,
  input  wire logic        spi_so_data,
  input  wire logic        tck,
  input  wire logic        scan_en,
  input  wire logic        scan_data,
  output logic             loop_mode,
  output logic             diff_drv_en,
  output logic             lock,
  output logic             hold,
  output logic             i2c_sel,
  output logic             host_clk,
  output logic             host_data,
  output logic             spi_cs_n,
  output logic             i2c_addr0,
  output logic             scl_out,
  output logic             scl_oe,
  output logic             sda_out,
  output logic             sda_oe,
  output logic             so_out,
  output logic             so_oe,
  output logic             int_n_out,
  output logic             int_n_oe,
  output logic             tdo_out,
  output logic             tdo_oe,
  output logic [3:0]       diff_sel,
  output logic [3:0]       apll_sel,
  output logic [13:0]      synth_mult,
  output logic [3:0]       fp_sel
);

  typedef struct packed {
    logic        strap_done;
    logic        reg_mode;
    logic        reg_mode_v;
    logic        mode_pin_prev;
    logic        loop_mode;
    logic        diff_drv_en;
    logic        lock;
    logic        hold;
    logic        i2c_sel;
    logic        host_clk;
    logic        host_data;
    logic        spi_cs_n;
    logic        i2c_addr0;
    logic        scl_oe;
    logic        sda_oe;
    logic        so_out;
    logic        so_oe;
    logic        int_pend;
    logic        tck_prev;
    logic        tdo_out;
    logic        tdo_oe;
    logic [3:0]  diff_sel;
    logic [3:0]  apll_sel;
    logic [13:0] synth_mult;
    logic [3:0]  fp_sel;
  } state_t;

  state_t st_q;
  state_t st_d;

  logic       mode_s;
  logic       diff_en_s;
  logic       i2c_en_s;
  logic       sck_s;
  logic       si_s;
  logic       sel_s;
  logic       tck_s;
  logic       scan_en_s;

  // all pin inputs except scan_data pass two flip-flops
  sync2 #(
    .W (8)
  ) u_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .d      ({mode_pin, diff_en_pin, i2c_en_pin, sck_scl_in,
              si_sda_in, select_or_addr0_pin, tck, scan_en}),
    .q      ({mode_s, diff_en_s, i2c_en_s, sck_s, si_s, sel_s, tck_s, scan_en_s})
  );

  function automatic logic [3:0] clamp_sel(input logic [3:0] v, input logic [3:0] mx);
    clamp_sel = (v > mx) ? mx : v;
  endfunction

  always_comb begin
    st_d = st_q;
    // first cycle after release takes the strap as default mode
    if (!st_q.strap_done) begin
      st_d.strap_done    = 1'b1;
      st_d.loop_mode     = mode_s;
      st_d.mode_pin_prev = mode_s;
    end else begin
      st_d.mode_pin_prev = mode_s;
      if (reg_wr && reg_addr == pin_ctrl_pkg::MODESEL_ADDR) begin
        st_d.reg_mode   = reg_wdata[pin_ctrl_pkg::MODESEL_BIT];
        st_d.reg_mode_v = 1'b1;
      end
      // register source or live pin steers the loop mode
      if (mode_from_reg && st_q.reg_mode_v) begin
        st_d.loop_mode = st_q.reg_mode;
      end else if (!mode_from_reg) begin
        st_d.loop_mode = mode_s;
      end
    end
    st_d.diff_drv_en = diff_en_s;
    st_d.lock        = tx_freq_locked & tx_phase_locked;
    st_d.hold        = tx_holdover;
    st_d.i2c_sel     = i2c_en_s;
    st_d.host_clk    = sck_s;
    st_d.host_data   = si_s;
    st_d.spi_cs_n    = i2c_en_s ? 1'b1 : sel_s;
    st_d.i2c_addr0   = i2c_en_s ? sel_s : 1'b0;
    st_d.scl_oe      = i2c_en_s & i2c_scl_drive_low;
    st_d.sda_oe      = i2c_en_s & i2c_sda_drive_low;
    st_d.so_oe       = ~i2c_en_s & ~sel_s;
    st_d.so_out      = i2c_en_s ? 1'b0 : spi_so_data;
    // sticky until acknowledged, the event wins over the ack
    if (status_event) begin
      st_d.int_pend = 1'b1;
    end else if (int_ack) begin
      st_d.int_pend = 1'b0;
    end
    // tdo updates on the falling edge of the test clock
    st_d.tck_prev = tck_s;
    if (!scan_en_s) begin
      st_d.tdo_oe = 1'b0;
    end else if (st_q.tck_prev && !tck_s) begin
      st_d.tdo_oe  = 1'b1;
      st_d.tdo_out = scan_data;
    end
    if (diff_sel_wr) begin
      st_d.diff_sel = clamp_sel(diff_sel_req, ethernet_mode ? pin_ctrl_pkg::DIFF_ETH_MAX
                                                           : pin_ctrl_pkg::DIFF_SONET_MAX);
    end
    if (apll_sel_wr) begin
      st_d.apll_sel = clamp_sel(apll_sel_req, ethernet_mode ? pin_ctrl_pkg::APLL_ETH_MAX
                                                           : pin_ctrl_pkg::APLL_SONET_MAX);
    end
    if (synth_mult_wr) begin
      st_d.synth_mult = (synth_mult_req > pin_ctrl_pkg::SYNTH_MULT_MAX) ?
                        pin_ctrl_pkg::SYNTH_MULT_MAX : synth_mult_req;
    end
    if (fp_sel_wr) begin
      st_d.fp_sel = fp_sel_req;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q            <= '0;
      st_q.spi_cs_n   <= 1'b1;
      st_q.diff_sel   <= pin_ctrl_pkg::DIFF_SEL_DEF;
      st_q.apll_sel   <= pin_ctrl_pkg::APLL_SEL_DEF;
      st_q.synth_mult <= pin_ctrl_pkg::SYNTH_MULT_DEF;
      st_q.fp_sel     <= pin_ctrl_pkg::FP_SEL_DEF;
    end else begin
      st_q <= st_d;
    end
  end

  assign loop_mode   = st_q.loop_mode;
  assign diff_drv_en = st_q.diff_drv_en;
  assign lock        = st_q.lock;
  assign hold        = st_q.hold;
  assign i2c_sel     = st_q.i2c_sel;
  assign host_clk    = st_q.host_clk;
  assign host_data   = st_q.host_data;
  assign spi_cs_n    = st_q.spi_cs_n;
  assign i2c_addr0   = st_q.i2c_addr0;
  assign scl_out     = 1'b0;
  assign scl_oe      = st_q.scl_oe;
  assign sda_out     = 1'b0;
  assign sda_oe      = st_q.sda_oe;
  assign so_out      = st_q.so_out;
  assign so_oe       = st_q.so_oe;
  assign int_n_out   = 1'b0;
  assign int_n_oe    = st_q.int_pend;
  assign tdo_out     = st_q.tdo_out;
  assign tdo_oe      = st_q.tdo_oe;
  assign diff_sel    = st_q.diff_sel;
  assign apll_sel    = st_q.apll_sel;
  assign synth_mult  = st_q.synth_mult;
  assign fp_sel      = st_q.fp_sel;

endmodule // pin_ctrl

// ### verification/pin_ctrl_asserts.sv
`timescale 1ns/1ps
module pin_ctrl_asserts (
  input wire logic       clk,
  input wire logic       arst_n,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       mode_from_reg,
  input wire logic       ethernet_mode,
  input wire logic [3:0] diff_sel_req,
  input wire logic       diff_sel_wr,
  input wire logic       tx_freq_locked,
  input wire logic       tx_phase_locked,
  input wire logic       status_event,
  input wire logic       int_ack,
  input wire logic       diff_en_pin,
  input wire logic       i2c_en_pin,
  input wire logic       select_or_addr0_pin,
  input wire logic       loop_mode,
  input wire logic       diff_drv_en,
  input wire logic       lock,
  input wire logic       i2c_sel,
  input wire logic       spi_cs_n,
  input wire logic       i2c_addr0,
  input wire logic       int_n_oe,
  input wire logic [3:0] diff_sel
);
  logic [2:0] up_q;
  logic [3:0] diff_exp;
  logic       ok;
  // cycles since reset release, saturating
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) up_q <= 3'h0;
    else if (!up_q[2]) up_q <= up_q + 3'h1;
  end
  assign ok = up_q[2];
  always_comb begin
    diff_exp = diff_sel_req;
    if (ethernet_mode && diff_sel_req > 4'h5) diff_exp = 4'h5;
    if (!ethernet_mode && diff_sel_req > 4'h7) diff_exp = 4'h7;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence mode_wr_s;
    reg_wr && reg_addr == 8'h1f && mode_from_reg;
  endsequence
  sequence mode_quiet_s;
    (!reg_wr && mode_from_reg) [*2];
  endsequence
  a_mode_reg: assert property (mode_wr_s ##1 mode_quiet_s |=>
    loop_mode == $past(reg_wdata[0], 3)) else $error("loop mode");
  a_lock_both: assert property (ok |->
    lock == $past(tx_freq_locked && tx_phase_locked)) else $error("lock");
  a_drv_follow: assert property (ok |->
    diff_drv_en == $past(diff_en_pin, 3)) else $error("drv");
  a_iface_sel: assert property (ok |->
    i2c_sel == $past(i2c_en_pin, 3)) else $error("iface");
  a_select_map: assert property (ok |-> (i2c_sel ?
    (spi_cs_n && i2c_addr0 == $past(select_or_addr0_pin, 3)) :
    (!i2c_addr0 && spi_cs_n == $past(select_or_addr0_pin, 3)))) else $error("select");
  a_int_set: assert property (status_event |=> int_n_oe) else $error("int set");
  a_int_clear: assert property (int_n_oe && int_ack && !status_event |=>
    !int_n_oe) else $error("int clear");
  a_diff_clamp: assert property (diff_sel_wr |=>
    diff_sel == $past(diff_exp)) else $error("diff sel");
endmodule // pin_ctrl_asserts
bind pin_ctrl pin_ctrl_asserts chk_u (.*);

// ### verification/host_model.sv
`timescale 1ns/1ps
module host_model (
  input  wire logic run,
  output logic      tck,
  output logic      scan_data
);
  // test clock runs only inside a frame and idles low
  initial begin
    tck = 1'b0;
    forever begin
      #160;
      tck = run ? ~tck : 1'b0;
    end
  end
  // new bit on each rise so every falling edge shows fresh data
  initial scan_data = 1'b0;
  always @(posedge tck) scan_data <= ~scan_data;
endmodule // host_model

// ### verification/pin_ctrl_tb.sv
`timescale 1ns/1ps
module pin_ctrl_tb;
  logic clk, arst_n, mode_pin, diff_en_pin, i2c_en_pin, ethernet_mode, reg_wr, mode_from_reg;
  logic [7:0] reg_addr, reg_wdata;
  logic [3:0] diff_sel_req, apll_sel_req, fp_sel_req, diff_sel, apll_sel, fp_sel;
  logic [13:0] synth_mult_req, synth_mult;
  logic diff_sel_wr, apll_sel_wr, synth_mult_wr, fp_sel_wr, tx_freq_locked, tx_phase_locked;
  logic tx_holdover, status_event, int_ack, sck_scl_in, si_sda_in, select_or_addr0_pin;
  logic i2c_scl_drive_low, i2c_sda_drive_low, spi_so_data, tck, scan_en, scan_data, run;
  logic loop_mode, diff_drv_en, lock, hold, i2c_sel, host_clk, host_data, spi_cs_n, i2c_addr0;
  logic scl_out, scl_oe, sda_out, sda_oe, so_out, so_oe, int_n_out, int_n_oe, tdo_out, tdo_oe;
  logic e;
  int miscompares, comparisons;
  // open-drain wires: pulled up unless the device pulls low
  assign sck_scl_in = !scl_oe;
  assign si_sda_in = !sda_oe;
  pin_ctrl dut_u (.*);
  host_model host_u (.*);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input logic [13:0] got, input logic [13:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    if (miscompares == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic t_reset(input logic m);
    arst_n = 1'b0;
    mode_pin = m;
    cyc(10);
    chk(lock, 0);
    chk(spi_cs_n, 1);
    chk(synth_mult, 14'h0100);
    chk(diff_sel, 7);
    chk(apll_sel, 4);
    chk(fp_sel, 0);
    arst_n = 1'b1;
    cyc(2);
    chk(loop_mode, m);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic exp);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    cyc(1);
    reg_wr = 1'b0;
    cyc(3);
    chk(loop_mode, exp);
  endtask
  task automatic t_mode;
    mode_from_reg = 1'b1;
    wr(8'h1f, 8'h00, 0);
    wr(8'h1e, 8'h01, 0);
    wr(8'h1f, 8'h01, 1);
    mode_from_reg = 1'b0;
    mode_pin = 1'b0;
    cyc(5);
    chk(loop_mode, 0);
  endtask
  task automatic t_pins;
    for (int k = 0; k < 4; k++) begin
      i2c_en_pin = k[0];
      select_or_addr0_pin = k[1];
      diff_en_pin = k[1];
      i2c_scl_drive_low = k[1];
      i2c_sda_drive_low = k[1];
      spi_so_data = k[1];
      cyc(6);
      chk(spi_cs_n, k[0] | k[1]);
      chk(so_out, !k[0] & k[1]);
      chk(i2c_sel, k[0]);
      chk(diff_drv_en, k[1]);
      chk(i2c_addr0, k[0] & k[1]);
      chk(so_oe, !k[0] && !k[1]);
      chk(scl_oe, k[0] & k[1]);
      chk(host_data, !(k[0] & k[1]));
      chk(host_clk, !(k[0] & k[1]));
    end
  endtask
  task automatic t_status;
    for (int k = 0; k < 4; k++) begin
      tx_freq_locked = k[0];
      tx_phase_locked = k[1];
      tx_holdover = k[0];
      cyc(2);
      chk(lock, k == 3);
      chk(hold, k[0]);
    end
  endtask
  task automatic t_int;
    status_event = 1'b1;
    cyc(1);
    chk(int_n_oe, 1);
    int_ack = 1'b1;
    cyc(1);
    chk(int_n_oe, 1);
    status_event = 1'b0;
    cyc(1);
    int_ack = 1'b0;
    chk(int_n_oe, 0);
    chk(int_n_out, 0);
  endtask
  task automatic t_rates;
    for (int m = 0; m < 2; m++) begin
      ethernet_mode = m[0];
      diff_sel_req = m ? 4'h6 : 4'h9;
      apll_sel_req = m ? 4'h4 : 4'h9;
      synth_mult_req = m ? 14'h3fff : 14'h0000;
      fp_sel_req = 4'h3;
      {diff_sel_wr, apll_sel_wr, synth_mult_wr, fp_sel_wr} = 4'hf;
      cyc(1);
      {diff_sel_wr, apll_sel_wr, synth_mult_wr, fp_sel_wr} = 4'h0;
      chk(diff_sel, m ? 5 : 7);
      chk(apll_sel, m ? 3 : 4);
      chk(synth_mult, m ? 14'h30d4 : 14'h0000);
      chk(fp_sel, 3);
      cyc(1);
    end
  endtask
  task automatic t_tdo;
    scan_en = 1'b1;
    run = 1'b1;
    for (int i = 0; i < 100 && tdo_oe !== 1'b1; i++) cyc(1);
    chk(tdo_oe, 1);
    if (tdo_oe !== 1'b1) end_of_test;
    @(negedge tck);
    e = scan_data;
    cyc(5);
    chk(tdo_out, e);
    scan_en = 1'b0;
    run = 1'b0;
    cyc(5);
    chk(tdo_oe, 0);
  endtask
  initial begin
    arst_n = 1'b0;
    {mode_pin, diff_en_pin, i2c_en_pin, ethernet_mode, reg_wr, reg_addr, reg_wdata} = '0;
    {mode_from_reg, diff_sel_req, diff_sel_wr, apll_sel_req, apll_sel_wr, synth_mult_req} = '0;
    {synth_mult_wr, fp_sel_req, fp_sel_wr, tx_freq_locked, tx_phase_locked, tx_holdover} = '0;
    {status_event, int_ack, select_or_addr0_pin, i2c_scl_drive_low, i2c_sda_drive_low} = '0;
    {spi_so_data, scan_en, run} = '0;
    t_reset(1'b1);
    t_mode;
    t_pins;
    t_status;
    t_rates;
    t_int;
    t_tdo;
    t_reset(1'b0);
    end_of_test;
  end
endmodule // pin_ctrl_tb
